// ==== core/srs_regs.sv ====
// receiver control and read-out registers behind the control-bus register port
// assumes the control-bus decoder gives one-cycle write and read strobes with an address
`timescale 1ns/1ps
`include "srs_cfg.svh"

// How it works
// RQ1 - settings bit 3 set means the reported lock also needs pcm detected, clear means it does not.
// RQ2 - settings bit 2 set (default) mutes the output while burst preambles are seen.
// RQ3 - the host keeps settings bits 1 and 0 at zero on every write.
// RQ4 - interpolator status bit 2 reads 1 only once the mute sequence completed, 0 when unmuted.
// RQ5 - input status bit 2 reads 1 while burst preambles are detected.
// RQ6 - input status bit 1 reads 1 while bi-phase errors are detected.
// RQ7 - input status bit 0 reads 1 while the decoder is in lock.
// RQ8 - register 5a shows left status bits 15 to 0 at the same positions.
// RQ9 - register 5b shows left status bits 31 to 16 in register bits 15 to 0.
// RQ10 - register 5c shows left status bits 39 to 32 in bits 7 to 0 with zero above.
// RQ11 - register 5d shows right status bits 15 to 0 at the same positions.
// RQ12 - register 5e shows right status bits 31 to 16 in register bits 15 to 0.
// RQ13 - register 5f shows right status bits 39 to 32 in bits 7 to 0 with zero above.
// RQ14 - reads change nothing and reserved bits read as zero.
// RQ15 - status read-outs take only a complete error-free block as a whole.
module srs_regs
  import srs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  input wire logic dec_locked_i,
  input wire logic pcm_detected_i,
  input wire logic preamble_seen_i,
  input wire logic biphase_err_i,
  input wire logic mute_done_i,
  input wire logic [39:0] left_cs_i,
  input wire logic [39:0] right_cs_i,
  input wire logic cs_block_valid_i,
  input wire logic cs_block_err_i,
  output logic preamble_automute_o,
  output logic decoder_locked_flag_o,
  output logic preamble_automute_enable_o
);

  // =========================================================
  // settings register
  logic combine_pcm_ff;
  logic preamble_automute_enable_ff;
  logic nxt_combine_pcm;
  logic nxt_preamble_automute_enable;

  // bits 1 and 0 are not stored: the host must write them zero, so they steer nothing
  always_comb
  begin
    nxt_combine_pcm = combine_pcm_ff;
    nxt_preamble_automute_enable = preamble_automute_enable_ff;
    if (wr_stb_i && addr_i == `SRS_ADDR_SETTINGS)
    begin
      nxt_combine_pcm = wdata_i[`SRS_BIT_COMBINE_PCM]; // RQ1
      nxt_preamble_automute_enable = wdata_i[`SRS_BIT_AUTOMUTE_EN]; // RQ2
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      combine_pcm_ff <= `SRS_COMBINE_PCM_RESET;
      preamble_automute_enable_ff <= `SRS_AUTOMUTE_EN_RESET;
    end
    else
    begin
      combine_pcm_ff <= nxt_combine_pcm;
      preamble_automute_enable_ff <= nxt_preamble_automute_enable;
    end
  end

  // =========================================================
  // live status flags, registered once so reads see a stable snapshot
  logic preamble_seen_flag_ff;
  logic biphase_err_ff;
  logic decoder_locked_flag_ff;
  logic mute_done_ff;
  logic nxt_preamble_seen_flag;
  logic nxt_biphase_err;
  logic nxt_decoder_locked_flag;
  logic nxt_mute_done;

  always_comb
  begin
    nxt_preamble_seen_flag = preamble_seen_i; // RQ5
    nxt_biphase_err = biphase_err_i; // RQ6
    // with pcm combined, a non-pcm stream reports out of lock
    nxt_decoder_locked_flag = dec_locked_i && (pcm_detected_i || !combine_pcm_ff); // RQ1 RQ7
    nxt_mute_done = mute_done_i; // RQ4
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      preamble_seen_flag_ff <= 1'b0;
      biphase_err_ff <= 1'b0;
      decoder_locked_flag_ff <= 1'b0;
      mute_done_ff <= 1'b0;
    end
    else
    begin
      preamble_seen_flag_ff <= nxt_preamble_seen_flag;
      biphase_err_ff <= nxt_biphase_err;
      decoder_locked_flag_ff <= nxt_decoder_locked_flag;
      mute_done_ff <= nxt_mute_done;
    end
  end

  // auto mute request goes to the mute sequencer
  assign preamble_automute_o = preamble_automute_enable_ff && preamble_seen_flag_ff; // RQ2
  assign decoder_locked_flag_o = decoder_locked_flag_ff;
  assign preamble_automute_enable_o = preamble_automute_enable_ff;

  // =========================================================
  // channel status capture
  srs_cs_type left_cs_ff;
  srs_cs_type right_cs_ff;
  srs_cs_type nxt_left_cs;
  srs_cs_type nxt_right_cs;

  // both channels load together so a read never mixes two blocks
  always_comb
  begin
    nxt_left_cs = left_cs_ff;
    nxt_right_cs = right_cs_ff;
    if (cs_block_valid_i && !cs_block_err_i)
    begin
      nxt_left_cs = left_cs_i; // RQ15
      nxt_right_cs = right_cs_i; // RQ15
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      left_cs_ff <= '0;
      right_cs_ff <= '0;
    end
    else
    begin
      left_cs_ff <= nxt_left_cs;
      right_cs_ff <= nxt_right_cs;
    end
  end

  // =========================================================
  // read port: data one cycle after the strobe, reads have no side effect
  srs_word_type rdata_ff;
  logic rvalid_ff;
  srs_word_type nxt_rdata;
  logic nxt_rvalid;

  always_comb
  begin
    nxt_rdata = rdata_ff;
    nxt_rvalid = rd_stb_i;
    if (rd_stb_i)
    begin
      nxt_rdata = 16'h0000; // RQ14
      if (addr_i == `SRS_ADDR_INTERP)
        nxt_rdata[`SRS_BIT_MUTE_DONE] = mute_done_ff; // RQ4
      else if (addr_i == `SRS_ADDR_LINK)
      begin
        nxt_rdata[`SRS_BIT_PREAMBLE] = preamble_seen_flag_ff; // RQ5
        nxt_rdata[`SRS_BIT_BIPHASE_ERR] = biphase_err_ff; // RQ6
        nxt_rdata[`SRS_BIT_LOCKED] = decoder_locked_flag_ff; // RQ7
      end
      else if (addr_i == `SRS_ADDR_LEFT_LOW)
        nxt_rdata = left_cs_ff[15:0]; // RQ8
      else if (addr_i == `SRS_ADDR_LEFT_MID)
        nxt_rdata = left_cs_ff[31:16]; // RQ9
      else if (addr_i == `SRS_ADDR_LEFT_HIGH)
        nxt_rdata = {8'h00, left_cs_ff[39:32]}; // RQ10
      else if (addr_i == `SRS_ADDR_RIGHT_LOW)
        nxt_rdata = right_cs_ff[15:0]; // RQ11
      else if (addr_i == `SRS_ADDR_RIGHT_MID)
        nxt_rdata = right_cs_ff[31:16]; // RQ12
      else if (addr_i == `SRS_ADDR_RIGHT_HIGH)
        nxt_rdata = {8'h00, right_cs_ff[39:32]}; // RQ13
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign rdata_o = rdata_ff;
  assign rvalid_o = rvalid_ff;

  // =========================================================
  // checks
  a_lock_combine_pcm: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ1
    (combine_pcm_ff && !pcm_detected_i) |=> !decoder_locked_flag_ff)
    else $error("lock reported without pcm while combined");
  a_lock_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ7
    (!combine_pcm_ff && dec_locked_i) |=> decoder_locked_flag_ff)
    else $error("lock flag missed decoder lock");
  a_automute_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ2
    preamble_automute_o |-> (preamble_automute_enable_ff && $past(preamble_seen_i)))
    else $error("auto mute without enable or preamble");
  a_mute_readout: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ4
    (rd_stb_i && addr_i == `SRS_ADDR_INTERP) |=> rdata_o == {13'h0, $past(mute_done_ff), 2'h0})
    else $error("mute status read wrong");
  a_link_readout: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ5
    (rd_stb_i && addr_i == `SRS_ADDR_LINK) |=> (rdata_o[15:3] == 13'h0000
      && rdata_o[2] == $past(preamble_seen_flag_ff) && rdata_o[1] == $past(biphase_err_ff)))
    else $error("input status read wrong");
  a_err_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ6
    biphase_err_i |=> biphase_err_ff)
    else $error("bi-phase error not flagged");
  a_left_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ10
    (rd_stb_i && addr_i == `SRS_ADDR_LEFT_HIGH) |=> rdata_o == {8'h00, $past(left_cs_ff[39:32])})
    else $error("left high read wrong");
  a_right_mid: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ12
    (rd_stb_i && addr_i == `SRS_ADDR_RIGHT_MID) |=> rdata_o == $past(right_cs_ff[31:16]))
    else $error("right mid read wrong");
  a_cs_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ15
    (!cs_block_valid_i || cs_block_err_i) |=> $stable(left_cs_ff) && $stable(right_cs_ff))
    else $error("status changed without a clean block");
  a_read_valid: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ14
    rd_stb_i |=> rvalid_o ##1 (rvalid_o == $past(rd_stb_i)))
    else $error("read answer timing wrong");

  // flags take their input level one edge later
  a_mute_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ4
    1'b1 |=> (mute_done_ff == $past(mute_done_i)))
    else $error("mute flag did not follow its input");
  a_preamble_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ5
    1'b1 |=> (preamble_seen_flag_ff == $past(preamble_seen_i)))
    else $error("preamble flag did not follow its input");
  a_err_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ6
    !biphase_err_i |=> !biphase_err_ff)
    else $error("bi-phase error flag stuck");
  a_lock_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ7
    !dec_locked_i |=> !decoder_locked_flag_ff)
    else $error("lock reported while decoder out of lock");

  // read-out words, compared with the snapshot held at the strobe edge
  a_link_lock: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ7
    (rd_stb_i && addr_i == `SRS_ADDR_LINK) |=> rdata_o[0] == $past(decoder_locked_flag_ff))
    else $error("lock bit read wrong");
  a_left_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ8
    (rd_stb_i && addr_i == `SRS_ADDR_LEFT_LOW) |=> rdata_o == $past(left_cs_ff[15:0]))
    else $error("left low read wrong");
  a_left_mid: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ9
    (rd_stb_i && addr_i == `SRS_ADDR_LEFT_MID) |=> rdata_o == $past(left_cs_ff[31:16]))
    else $error("left mid read wrong");
  a_right_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ11
    (rd_stb_i && addr_i == `SRS_ADDR_RIGHT_LOW) |=> rdata_o == $past(right_cs_ff[15:0]))
    else $error("right low read wrong");
  a_right_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ13
    (rd_stb_i && addr_i == `SRS_ADDR_RIGHT_HIGH)
      |=> rdata_o == {8'h00, $past(right_cs_ff[39:32])})
    else $error("right high read wrong");

  // a read of any other address must come back as zero
  logic rd_addr_mapped;
  assign rd_addr_mapped = (addr_i == `SRS_ADDR_INTERP) || (addr_i == `SRS_ADDR_LINK)
    || ((addr_i >= `SRS_ADDR_LEFT_LOW) && (addr_i <= `SRS_ADDR_RIGHT_HIGH));
  a_unmapped_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ14
    (rd_stb_i && !rd_addr_mapped) |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_read_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ14
    !rd_stb_i |=> $stable(rdata_o))
    else $error("read data changed without a read");
  a_rvalid_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ14
    !rd_stb_i |=> !rvalid_o)
    else $error("read answer without a read");

  // settings and capture
  a_settings_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ1
    (wr_stb_i && addr_i == `SRS_ADDR_SETTINGS)
      |=> (combine_pcm_ff == $past(wdata_i[`SRS_BIT_COMBINE_PCM]))
      && (preamble_automute_enable_ff == $past(wdata_i[`SRS_BIT_AUTOMUTE_EN])))
    else $error("settings write not taken");
  a_settings_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ2
    (wr_stb_i && addr_i != `SRS_ADDR_SETTINGS)
      |=> $stable(combine_pcm_ff) && $stable(preamble_automute_enable_ff))
    else $error("settings changed by a write to another address");
  a_cs_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ15
    (cs_block_valid_i && !cs_block_err_i)
      |=> (left_cs_ff == $past(left_cs_i)) && (right_cs_ff == $past(right_cs_i)))
    else $error("clean status block not captured");

  // reset values are seen at the first edge after release, so no reset disable here
  a_reset_defaults: assert property (@(posedge sys_clk_i) // RQ1 RQ2
    $rose(rst_n_i) |-> (combine_pcm_ff && preamble_automute_enable_ff && !rvalid_o))
    else $error("settings not at their defaults after reset");

endmodule

// ==== core/srs_cfg.svh ====
// register map, field positions and reset values of the receiver status bank
// assumes 8-bit register addresses and 16-bit register words
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH
`define SRS_ADDR_SETTINGS 8'h30
`define SRS_ADDR_INTERP 8'h18
`define SRS_ADDR_LINK 8'h59
`define SRS_ADDR_LEFT_LOW 8'h5a
`define SRS_ADDR_LEFT_MID 8'h5b
`define SRS_ADDR_LEFT_HIGH 8'h5c
`define SRS_ADDR_RIGHT_LOW 8'h5d
`define SRS_ADDR_RIGHT_MID 8'h5e
`define SRS_ADDR_RIGHT_HIGH 8'h5f
`define SRS_BIT_COMBINE_PCM 3
`define SRS_BIT_AUTOMUTE_EN 2
`define SRS_BIT_MUTE_DONE 2
`define SRS_BIT_PREAMBLE 2
`define SRS_BIT_BIPHASE_ERR 1
`define SRS_BIT_LOCKED 0
`define SRS_COMBINE_PCM_RESET 1'b1
`define SRS_AUTOMUTE_EN_RESET 1'b1
`define SRS_CS_BITS 40
`endif

// ==== core/srs_pkg.sv ====
// types shared by the receiver status bank
// assumes the constants of srs_cfg.svh
package srs_pkg;
  typedef logic [15:0] srs_word_type;
  typedef logic [39:0] srs_cs_type;
endpackage

// ==== bench/srs_host_model.sv ====
// host controller model: one-cycle strobes on the register port, reads sampled with rvalid at the next falling edge
// assumes it is stepped from the falling edge of sys_clk_i
`timescale 1ns/1ps
// ==================================================
// host bus driver
module srs_host_model
(
  input wire logic sys_clk_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  output logic wr_stb_o,
  output logic rd_stb_o,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o
);
  // idle bus at time zero
  initial
  begin
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 16'h0000;
  end
  // settings write; idle address shows the inverse so a stale value is never reused
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    wr_stb_o = 1'b1;
    addr_o = a;
    wdata_o = {d[15:2], 2'h0};
    @(negedge sys_clk_i);
    wr_stb_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~wdata_o;
  endtask
  // read: answer is registered at the taking edge and sampled at the next falling edge, half a cycle later
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(negedge sys_clk_i);
    rd_stb_o = 1'b1;
    addr_o = a;
    @(negedge sys_clk_i);
    v = rvalid_i;
    d = rdata_i;
    rd_stb_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule

// ==== bench/srs_regs_tb_top.sv ====
// self-checking bench of the receiver status registers
// assumes the host model drives the register port at the falling edge
`timescale 1ns/1ps
`include "srs_cfg.svh"
// ==================================================
// bench top
module srs_regs_tb_top;
  import srs_pkg::*;
  logic sys_clk_i, rst_n_i, wr_stb, rd_stb, rvalid, locked, pcm, pre, berr, mdone, csv, cse;
  logic automute, lock_flag, amen;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  srs_cs_type lcs, rcs;
  srs_word_type exp_w [6];
  int errors, checks, cyc;

  srs_host_model u_srs_host_model (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .wr_stb_o(wr_stb), .rd_stb_o(rd_stb), .addr_o(addr), .wdata_o(wdata));
  srs_regs u_srs_regs (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wr_stb_i(wr_stb),
    .rd_stb_i(rd_stb), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
    .dec_locked_i(locked), .pcm_detected_i(pcm), .preamble_seen_i(pre), .biphase_err_i(berr),
    .mute_done_i(mdone), .left_cs_i(lcs), .right_cs_i(rcs), .cs_block_valid_i(csv),
    .cs_block_err_i(cse), .preamble_automute_o(automute), .decoder_locked_flag_o(lock_flag),
    .preamble_automute_enable_o(amen));

  // 100 ns clock and a hang guard far above the expected run length
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    u_srs_host_model.rd(a, d, v);
    chk({15'h0, v}, 16'h0001);
    chk(d, exp);
  endtask
  // flags follow their levels with one cycle of latency; two is a safe margin
  task automatic settle();
    repeat (2) @(negedge sys_clk_i);
  endtask

  task automatic t_defaults();
    chk({15'h0, amen}, 16'h0001);
    rdchk(`SRS_ADDR_LINK, 16'h0000);
    rdchk(8'h20, 16'h0000);
    u_srs_host_model.wr(`SRS_ADDR_LINK, 16'h0000);
    settle();
    chk({15'h0, amen}, 16'h0001);
  endtask
  task automatic t_flags();
    locked = 1'b1;
    pre = 1'b1;
    berr = 1'b1;
    settle();
    rdchk(`SRS_ADDR_LINK, 16'h0006);
    chk({15'h0, automute}, 16'h0001);
    u_srs_host_model.wr(`SRS_ADDR_SETTINGS, 16'h0004);
    settle();
    rdchk(`SRS_ADDR_LINK, 16'h0007);
    chk({15'h0, lock_flag}, 16'h0001);
    u_srs_host_model.wr(`SRS_ADDR_SETTINGS, 16'h0000);
    settle();
    chk({14'h0, amen, automute}, 16'h0000);
    pcm = 1'b1;
    u_srs_host_model.wr(`SRS_ADDR_SETTINGS, 16'h000c);
    settle();
    rdchk(`SRS_ADDR_LINK, 16'h0007);
    locked = 1'b0;
    pre = 1'b0;
    berr = 1'b0;
    settle();
    rdchk(`SRS_ADDR_LINK, 16'h0000);
  endtask
  task automatic t_mute();
    mdone = 1'b1;
    settle();
    rdchk(`SRS_ADDR_INTERP, 16'h0004);
    mdone = 1'b0;
    settle();
    rdchk(`SRS_ADDR_INTERP, 16'h0000);
  endtask
  task automatic pulse(input logic e);
    @(negedge sys_clk_i);
    csv = 1'b1;
    cse = e;
    @(negedge sys_clk_i);
    csv = 1'b0;
    cse = 1'b0;
  endtask
  // a good block is captured, then a damaged one must leave it untouched
  task automatic t_cs();
    lcs = 40'hc3_8765_4321;
    rcs = 40'h5a_0f1e_2d3c;
    exp_w = '{lcs[15:0], lcs[31:16], {8'h00, lcs[39:32]},
              rcs[15:0], rcs[31:16], {8'h00, rcs[39:32]}};
    pulse(1'b0);
    lcs = ~lcs;
    rcs = ~rcs;
    pulse(1'b1);
    settle();
    repeat (2)
      for (int i = 0; i < 6; i++)
        rdchk(`SRS_ADDR_LEFT_LOW + 8'(i), exp_w[i]);
    settle();
    chk(rdata, exp_w[5]);
  endtask
  // mid-run reset brings the settings back to default and clears the captured status
  task automatic t_reset();
    pcm = 1'b0;
    u_srs_host_model.wr(`SRS_ADDR_SETTINGS, 16'h0000);
    settle();
    chk({15'h0, amen}, 16'h0000);
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    chk({15'h0, amen}, 16'h0001);
    rdchk(`SRS_ADDR_LEFT_LOW, 16'h0000);
    locked = 1'b1;
    settle();
    rdchk(`SRS_ADDR_LINK, 16'h0000);
    chk({15'h0, lock_flag}, 16'h0000);
  endtask

  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // reset for three cycles, then the scenarios in turn
  initial
  begin
    {locked, pcm, pre, berr, mdone, csv, cse} = 7'h00;
    lcs = 40'h0;
    rcs = 40'h0;
    rst_n_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    t_defaults();
    t_flags();
    t_mute();
    t_cs();
    t_reset();
    wrap_up();
  end
endmodule
